// [rtl/freq_synth_pkg.sv]
// Constants shared by the frequency synthesiser modules.
package freq_synth_pkg;
	localparam int ACC_W = 20;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int PW_CNT_W = 7;

	// Register byte offsets on the bus.
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_CLOCK_CTRL = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_ACC_LOW = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_ACC_HIGH = 6'h0c;
	localparam logic [ADDR_W-1:0] OFF_ACC_UPPER = 6'h10;
	localparam logic [ADDR_W-1:0] OFF_STEP_LOW = 6'h14;
	localparam logic [ADDR_W-1:0] OFF_STEP_HIGH = 6'h18;
	localparam logic [ADDR_W-1:0] OFF_STEP_UPPER = 6'h1c;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h20;

	// Field positions.
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int CTRL_POL_BIT = 4;
	localparam int CTRL_PFM_BIT = 0;
	localparam int CLK_PWS_LSB = 5;
	localparam int CLK_CKS_LSB = 0;
	localparam int STAT_WRAP_BIT = 0;

	// Clock source codes.
	localparam logic [2:0] SRC_HF_OSC = 3'h0;
	localparam logic [2:0] SRC_SYS_CLK = 3'h1;
	localparam logic [2:0] SRC_LOGIC_CELL1 = 3'h2;

	// Input clock edges between a low step write and the buffer load.
	localparam logic [1:0] STEP_LOAD_EDGES = 2'h2;
	localparam logic [ACC_W-1:0] ACC_RESET = 20'h00000;
	localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
endpackage

// [rtl/synth_core_if.sv]
// Signals between the synthesiser core, its tick source and its shaper.
`timescale 1ns/1ps
interface synth_core_if;
	logic enable;
	logic [2:0] src_sel;
	logic tick;
	logic carry;
	logic pulse_mode;
	logic polarity;
	logic [2:0] pulse_width;
	logic shaped_out;

	modport gen (input enable, input src_sel, output tick);
	modport shaper (input tick, input carry, input pulse_mode,
		input polarity, input pulse_width, output shaped_out);
	modport core (output enable, output src_sel, output carry,
		output pulse_mode, output polarity, output pulse_width,
		input tick, input shaped_out);
endinterface

// [rtl/synth_tick_gen.sv]
// Selects the input clock source and turns its rising edges into ticks.
`timescale 1ns/1ps
module synth_tick_gen
	import freq_synth_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Clock sources
	input wire logic internal_hf_osc,
	input wire logic logic_cell1_output,
	// Core link
	synth_core_if.gen bus
);
	typedef struct packed {
		logic hf_prev;
		logic lc_prev;
		logic tick;
	} tick_state_t;

	tick_state_t s_reg;
	tick_state_t s_next;

	always_comb
	begin
		s_next = s_reg;
		s_next.hf_prev = internal_hf_osc;
		s_next.lc_prev = logic_cell1_output;
		s_next.tick = 1'b0;
		// The adder moves on a source edge, or on every bus clock while the system clock source is selected.
		if (bus.enable)
		begin
			unique case (bus.src_sel)
				SRC_HF_OSC: s_next.tick = internal_hf_osc && !s_reg.hf_prev;
				SRC_SYS_CLK: s_next.tick = 1'b1;
				SRC_LOGIC_CELL1:
					s_next.tick = logic_cell1_output && !s_reg.lc_prev;
				default: s_next.tick = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign bus.tick = s_reg.tick;
endmodule

// [rtl/synth_output_shaper.sv]
// Turns the raw carry into a toggled or stretched output with polarity.
`timescale 1ns/1ps
module synth_output_shaper
	import freq_synth_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Core link
	synth_core_if.shaper bus
);
	typedef struct packed {
		logic toggle;
		logic active;
		logic [PW_CNT_W-1:0] cnt;
		logic out;
	} shape_state_t;

	shape_state_t s_reg;
	shape_state_t s_next;

	always_comb
	begin
		s_next = s_reg;
		if (bus.tick)
		begin
			if (bus.carry)
			begin
				s_next.toggle = !s_reg.toggle;
				// A new carry restarts the pulse, so it never drops if the
				// width exceeds the overflow period.
				s_next.active = 1'b1;
				s_next.cnt = PW_CNT_W'((1 << bus.pulse_width) - 1);
			end
			else if (s_reg.active)
			begin
				if (s_reg.cnt == '0)
					s_next.active = 1'b0;
				else
					s_next.cnt = s_reg.cnt - 1'b1;
			end
		end
		s_next.out = (bus.pulse_mode ? s_next.active : s_next.toggle)
			^ bus.polarity;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign bus.shaped_out = s_reg.out;
endmodule

// [rtl/freq_synth.sv]
// Numerically controlled frequency synthesiser with an Avalon-MM slave.
//
// Overview of operation
// - The phase accumulator is twenty bits wide.
// - Each selected input clock edge adds the active step to the accumulator.
// - The adder advances only on edges of the selected source.
// - The carry out of each wrap is the raw overflow output.
// - Every wrap also raises the interrupt event.
// - Overflow rate equals input rate times step over two to the twentieth.
// - A three-bit field picks oscillator, system clock or logic cell one.
// - Software reads and writes the accumulator as three bytes.
// - The step is three bytes, low, high and upper.
// - When enabled, a low step write loads the buffer on the second edge.
// - When disabled, the step buffer follows any step write at once.
// - Step bytes are read and write; the active buffer is hidden.
// - The carry is toggled or stretched, then sent to peripherals and pin.
// - With pulse mode clear, each overflow toggles the output.
// - With pulse mode set, the output pulses from the edge after overflow.
// - A three-bit width field sets the pulse length in input periods.
// - Reset clears every register, accumulator and step included.
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module freq_synth
	import freq_synth_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Avalon-MM slave
	input wire logic [freq_synth_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [freq_synth_pkg::DATA_W-1:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [freq_synth_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	// Clock sources
	input wire logic internal_hf_osc,
	input wire logic logic_cell1_output,
	// Synthesiser outputs
	output logic synth_out,
	output logic acc_carry_out,
	output logic acc_wrap_irq
);
	typedef struct packed {
		logic wait_b;
		logic [BYTE_W-1:0] rdata;
		logic enable;
		logic polarity;
		logic pulse_mode;
		logic [2:0] pulse_width;
		logic [2:0] src_sel;
		logic [ACC_W-1:0] acc;
		logic [ACC_W-1:0] step;
		logic [ACC_W-1:0] step_act;
		logic [1:0] load_cnt;
		logic carry;
		logic irq;
		logic wrap_flag;
	} synth_state_t;

	synth_state_t s_reg;
	synth_state_t s_next;
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [ACC_W:0] sum;
	logic req;
	logic wr_go;
	logic [BYTE_W-1:0] wbyte;

	synth_core_if bus ();

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops; the rest uses the copy.

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	assign rst_n = rst_sync_reg[1];

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
	endfunction

	function automatic logic [BYTE_W-1:0] get_byte(
		input logic [ACC_W-1:0] v, input int idx);
		logic [23:0] wide;
		wide = {4'h0, v};
		get_byte = wide[idx*BYTE_W +: BYTE_W];
	endfunction

	function automatic logic [ACC_W-1:0] put_byte(
		input logic [ACC_W-1:0] v, input int idx,
		input logic [BYTE_W-1:0] b);
		logic [23:0] wide;
		wide = {4'h0, v};
		wide[idx*BYTE_W +: BYTE_W] = b;
		put_byte = wide[ACC_W-1:0];
	endfunction

	function automatic logic [BYTE_W-1:0] read_mux(
		input logic [ADDR_W-1:0] a, input synth_state_t s,
		input logic out_now);
		logic [BYTE_W-1:0] r;
		r = BYTE_RESET;
		if (hit(a, OFF_CONTROL))
		begin
			r[CTRL_EN_BIT] = s.enable;
			r[CTRL_OUT_BIT] = out_now;
			r[CTRL_POL_BIT] = s.polarity;
			r[CTRL_PFM_BIT] = s.pulse_mode;
		end
		else if (hit(a, OFF_CLOCK_CTRL))
		begin
			r[CLK_PWS_LSB +: 3] = s.pulse_width;
			r[CLK_CKS_LSB +: 3] = s.src_sel;
		end
		else if (hit(a, OFF_ACC_LOW))
			r = get_byte(s.acc, 0);
		else if (hit(a, OFF_ACC_HIGH))
			r = get_byte(s.acc, 1);
		else if (hit(a, OFF_ACC_UPPER))
			r = get_byte(s.acc, 2);
		else if (hit(a, OFF_STEP_LOW))
			r = get_byte(s.step, 0);
		else if (hit(a, OFF_STEP_HIGH))
			r = get_byte(s.step, 1);
		else if (hit(a, OFF_STEP_UPPER))
			r = get_byte(s.step, 2);
		else if (hit(a, OFF_STATUS))
			r[STAT_WRAP_BIT] = s.wrap_flag;
		read_mux = r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// The carry out is the bit above the accumulator; overflow rate is
	// therefore tick rate times step over two to the twentieth.
	assign sum = {1'b0, s_reg.acc} + {1'b0, s_reg.step_act};
	assign req = read || write;
	assign wr_go = write && !s_reg.wait_b && byteenable[0];
	assign wbyte = writedata[BYTE_W-1:0];

	always_comb
	begin
		s_next = s_reg;

		// One wait cycle, then the access completes; read data is
		// captured during the wait so it stands at the completing edge.
		s_next.wait_b = !(req && s_reg.wait_b);
		if (read && s_reg.wait_b)
			s_next.rdata = read_mux(address, s_reg, s_reg.enable ?
				bus.shaped_out : 1'b0);

		// Carry is held between ticks, so it lasts exactly one input period;
		// the event is recomputed every cycle, so it lasts one system cycle.
		if (bus.tick)
		begin
			s_next.acc = sum[ACC_W-1:0];
			s_next.carry = sum[ACC_W];
			if (s_reg.load_cnt != 2'h0)
			begin
				s_next.load_cnt = s_reg.load_cnt - 2'h1;
				if (s_reg.load_cnt == 2'h1)
					s_next.step_act = s_reg.step;
			end
		end
		s_next.irq = bus.tick && sum[ACC_W];

		if (!s_reg.enable)
		begin
			// While stopped the buffer tracks the bytes directly.
			s_next.step_act = s_reg.step;
			s_next.load_cnt = 2'h0;
			s_next.carry = 1'b0;
			s_next.irq = 1'b0;
		end

		// Software writes win over a concurrent tick on the accumulator.
		if (wr_go)
		begin
			if (hit(address, OFF_CONTROL))
			begin
				s_next.enable = wbyte[CTRL_EN_BIT];
				s_next.polarity = wbyte[CTRL_POL_BIT];
				s_next.pulse_mode = wbyte[CTRL_PFM_BIT];
			end
			else if (hit(address, OFF_CLOCK_CTRL))
			begin
				s_next.pulse_width = wbyte[CLK_PWS_LSB +: 3];
				s_next.src_sel = wbyte[CLK_CKS_LSB +: 3];
			end
			else if (hit(address, OFF_ACC_LOW))
				s_next.acc = put_byte(s_next.acc, 0, wbyte);
			else if (hit(address, OFF_ACC_HIGH))
				s_next.acc = put_byte(s_next.acc, 1, wbyte);
			else if (hit(address, OFF_ACC_UPPER))
				s_next.acc = put_byte(s_next.acc, 2, wbyte);
			else if (hit(address, OFF_STEP_LOW))
			begin
				s_next.step = put_byte(s_reg.step, 0, wbyte);
				// Only the low byte arms the load, which is why the other
				// two bytes must be written first.
				if (s_reg.enable)
					s_next.load_cnt = STEP_LOAD_EDGES;
			end
			else if (hit(address, OFF_STEP_HIGH))
				s_next.step = put_byte(s_reg.step, 1, wbyte);
			else if (hit(address, OFF_STEP_UPPER))
				s_next.step = put_byte(s_reg.step, 2, wbyte);
			else if (hit(address, OFF_STATUS) && wbyte[STAT_WRAP_BIT])
				s_next.wrap_flag = 1'b0;
		end

		// A wrap in the clearing cycle keeps the flag set.
		if (s_next.irq)
			s_next.wrap_flag = 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_reg <= '0;
			s_reg.wait_b <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Tick source and output shaper.

	assign bus.enable = s_reg.enable;
	assign bus.src_sel = s_reg.src_sel;
	assign bus.carry = s_reg.carry;
	assign bus.pulse_mode = s_reg.pulse_mode;
	assign bus.polarity = s_reg.polarity;
	assign bus.pulse_width = s_reg.pulse_width;

	synth_tick_gen u_tick (
		.clock(clock),
		.rst_n(rst_n),
		.internal_hf_osc(internal_hf_osc),
		.logic_cell1_output(logic_cell1_output),
		.bus(bus.gen)
	);

	synth_output_shaper u_shape (
		.clock(clock),
		.rst_n(rst_n),
		.bus(bus.shaper)
	);

	assign readdata = {{(DATA_W-BYTE_W){1'b0}}, s_reg.rdata};
	assign waitrequest = s_reg.wait_b;
	assign synth_out = bus.shaped_out;
	assign acc_carry_out = s_reg.carry;
	assign acc_wrap_irq = s_reg.irq;
endmodule

// [verification/freq_synth_assertions.sv]
// Bus, carry and interrupt checks for the frequency synthesiser.
`timescale 1ns/1ps
module freq_synth_assertions
	import freq_synth_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Avalon-MM slave
	input wire logic [freq_synth_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [freq_synth_pkg::DATA_W-1:0] readdata,
	input wire logic waitrequest,
	// Synthesiser outputs
	input wire logic synth_out,
	input wire logic acc_carry_out,
	input wire logic acc_wrap_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	////////////////////////////////////////////////////////////////////////
	chk_bus_answer: assert property (
		(read || write) && waitrequest |=> !waitrequest)
		else $error("Bus request not answered after one wait.");
	chk_wait_short: assert property (
		!waitrequest |=> waitrequest)
		else $error("Wait request low for more than one cycle.");
	chk_idle_wait: assert property (
		waitrequest && !read && !write |=> waitrequest)
		else $error("Bus answered without a request.");
	chk_rd_upper: assert property (
		!waitrequest |-> readdata[31:8] == 24'h000000)
		else $error("Read data upper bits not zero.");
	chk_unmapped_zero: assert property (
		read && !waitrequest && address[5:2] > 4'h8 |-> readdata == 32'h0)
		else $error("Unmapped read not zero.");
	chk_irq_carry: assert property (
		acc_wrap_irq |-> acc_carry_out)
		else $error("Interrupt without carry.");
	chk_carry_irq: assert property (
		$rose(acc_carry_out) |-> acc_wrap_irq)
		else $error("Carry rose without interrupt.");
	chk_reset_quiet: assert property (
		$rose(arst_n) |-> waitrequest && !acc_carry_out && !synth_out)
		else $error("Outputs not cleared by reset.");

	////////////////////////////////////////////////////////////////////////
	cover property (read && !waitrequest);
	cover property (write && !waitrequest);
	cover property ($rose(acc_wrap_irq));
endmodule

bind freq_synth freq_synth_assertions chk (.clock, .arst_n, .address,
	.read, .write, .readdata, .waitrequest, .synth_out, .acc_carry_out,
	.acc_wrap_irq);

// [verification/testbench.sv]
// Directed register and accumulator tests for the frequency synthesiser.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
	$display("ERROR at %0t got %h exp %h", $time, a, e); end end
module testbench;
	import freq_synth_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] address = 6'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [DATA_W-1:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'h1;
	logic internal_hf_osc = 1'b0;
	logic logic_cell1_output = 1'b0;
	logic [DATA_W-1:0] readdata;
	logic waitrequest, synth_out, acc_carry_out, acc_wrap_irq;
	int n_errors = 0;
	int tests_run = 0;
	logic [ACC_W-1:0] va, vb;
	logic [7:0] q;

	always #50 clock = ~clock;

	freq_synth uut (.clock, .arst_n, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .internal_hf_osc,
		.logic_cell1_output, .synth_out, .acc_carry_out, .acc_wrap_irq);

	////////////////////////////////////////////////////////////////////////
	task finish_test;
	begin
		$display("Errors %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	// The request is held until waitrequest is seen low at an edge.
	task bus(input logic w, input logic [ADDR_W-1:0] a,
		input logic [7:0] d, output logic [7:0] r);
		int i;
		logic ok;
	begin
		read <= !w;
		write <= w;
		address <= a;
		writedata <= {24'h000000, d};
		i = 0;
		do
		begin
			@(posedge clock);
			i++;
		end
		while (waitrequest !== 1'b0 && i < 20);
		ok = (waitrequest === 1'b0);
		r = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
		if (!ok)
		begin
			n_errors++;
			finish_test();
		end
	end
	endtask

	task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [7:0] r;
	begin
		bus(1'b1, a, d, r);
	end
	endtask

	task rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
	begin
		bus(1'b0, a, 8'h00, q);
		`CHK(q, e)
	end
	endtask

	task racc(output logic [ACC_W-1:0] v);
		logic [7:0] b0, b1, b2;
	begin
		bus(1'b0, OFF_ACC_LOW, 8'h00, b0);
		bus(1'b0, OFF_ACC_HIGH, 8'h00, b1);
		bus(1'b0, OFF_ACC_UPPER, 8'h00, b2);
		v = {b2[3:0], b1, b0};
	end
	endtask

	// One rising edge on a source; zero is the oscillator.
	task edges(input logic src);
	begin
		if (src)
			logic_cell1_output <= 1'b1;
		else
			internal_hf_osc <= 1'b1;
		repeat (2) @(posedge clock);
		internal_hf_osc <= 1'b0;
		logic_cell1_output <= 1'b0;
		repeat (2) @(posedge clock);
	end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		for (int k = 0; k <= 8; k++)
			rdc(6'(k * 4), 8'h00);
		wr(6'h24, 8'hff);
		rdc(6'h24, 8'h00);
		wr(OFF_STEP_LOW, 8'h45);
		wr(OFF_STEP_HIGH, 8'h23);
		wr(OFF_STEP_UPPER, 8'hf1);
		rdc(OFF_STEP_LOW, 8'h45);
		rdc(OFF_STEP_HIGH, 8'h23);
		rdc(OFF_STEP_UPPER, 8'h01);
		wr(OFF_ACC_LOW, 8'hf0);
		wr(OFF_ACC_HIGH, 8'hff);
		wr(OFF_ACC_UPPER, 8'h0f);
		racc(va);
		`CHK(va, 20'hffff0)
		wr(OFF_CLOCK_CTRL, 8'h00);
		wr(OFF_CONTROL, 8'h80);
		edges(1'b0);
		`CHK(acc_carry_out, 1'b1)
		racc(va);
		`CHK(va, 20'h12335)
		rdc(OFF_STATUS, 8'h01);
		wr(OFF_STATUS, 8'h01);
		rdc(OFF_STATUS, 8'h00);
		edges(1'b0);
		`CHK(acc_carry_out, 1'b0)
		`CHK(synth_out, 1'b1)
		racc(va);
		`CHK(va, 20'h2467a)
		// Upper and high first, so the active step stays whole meanwhile.
		wr(OFF_STEP_HIGH, 8'h00);
		wr(OFF_STEP_UPPER, 8'h00);
		wr(OFF_STEP_LOW, 8'h10);
		edges(1'b0);
		racc(va);
		`CHK(va, 20'h369bf)
		edges(1'b0);
		racc(va);
		edges(1'b0);
		racc(vb);
		`CHK(vb - va, 20'h00010)
		wr(OFF_CLOCK_CTRL, 8'h02);
		edges(1'b0);
		racc(va);
		`CHK(va, vb)
		edges(1'b1);
		racc(va);
		`CHK(va, vb + 20'h00010)
		// The system clock source ticks on every cycle while it is selected.
		wr(OFF_CLOCK_CTRL, 8'h01);
		wr(OFF_CLOCK_CTRL, 8'h20);
		racc(va);
		`CHK(va, vb + 20'h00040)
		wr(OFF_CONTROL, 8'h81);
		rdc(OFF_CONTROL, 8'h81);
		rdc(OFF_CLOCK_CTRL, 8'h20);
		wr(OFF_ACC_LOW, 8'hf0);
		wr(OFF_ACC_HIGH, 8'hff);
		wr(OFF_ACC_UPPER, 8'h0f);
		// The event lasts one system cycle, so it is looked at edge by edge.
		internal_hf_osc <= 1'b1;
		repeat (2) @(posedge clock);
		internal_hf_osc <= 1'b0;
		@(posedge clock);
		`CHK(acc_wrap_irq, 1'b1)
		`CHK(acc_carry_out, 1'b1)
		@(posedge clock);
		`CHK(acc_wrap_irq, 1'b0)
		`CHK(synth_out, 1'b0)
		edges(1'b0);
		`CHK(synth_out, 1'b1)
		edges(1'b0);
		`CHK(synth_out, 1'b1)
		edges(1'b0);
		`CHK(synth_out, 1'b0)
		wr(OFF_CONTROL, 8'h91);
		rdc(OFF_CONTROL, 8'hb1);
		`CHK(synth_out, 1'b1)
		byteenable <= 4'h0;
		wr(OFF_STEP_HIGH, 8'h55);
		byteenable <= 4'h1;
		rdc(OFF_STEP_HIGH, 8'h00);
		// A second reset in mid-run must clear everything again.
		arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK(synth_out, 1'b0)
		rdc(OFF_ACC_LOW, 8'h00);
		rdc(OFF_STEP_LOW, 8'h00);
		rdc(OFF_CONTROL, 8'h00);
		finish_test();
	end
endmodule
